// ===== dv/adcdo_checker.sv
`timescale 1ns/1ps
// ------
// port checker
// ------
module adcdo_checker (
  input wire logic                   sys_clk,
  input wire logic                   rst_b,
  input wire logic                   spi_csb_b,
  input wire logic                   spi_sdio_oe,
  input wire logic                   adc_valid,
  input wire logic                   level_alarm_pin,
  input wire logic                   link_pll_on,
  input wire logic                   link_ser_on,
  input wire logic                   lane_valid,
  input wire logic                   lane_ready,
  input wire adcdo_pkg::adcdo_lane_s lane_word
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // lane side and serial port answers
  a_lane_word_hold: assert property (lane_valid && !lane_ready |=> lane_valid && $stable(lane_word))
    else $error("lane word changed while stalled");
  a_lane_ctrl_code: assert property (lane_valid && lane_word.ctrl |->
    lane_word.data inside {16'hBCBC, 16'h1C1C, 16'h7C7C}) else $error("bad control word");
  a_oe_csb_drop: assert property (spi_csb_b |=> !spi_sdio_oe) else $error("sdio driven idle");
  a_oe_needs_sel: assert property ($rose(spi_sdio_oe) |-> !spi_csb_b)
    else $error("sdio driven unselected");
  a_rst_lane_idle: assert property ($rose(rst_b) |-> !lane_valid && !spi_sdio_oe)
    else $error("outputs busy after reset");
  a_valid_after_link: assert property ($rose(lane_valid) |-> $past(link_ser_on) ||
    $past(link_ser_on, 2)) else $error("word pushed while link off");
  // power state of the link; state lags the field by one edge
  a_pll_off_ser: assert property (!link_pll_on [*2] |-> !link_ser_on)
    else $error("serializer on with pll off");
  a_ser_needs_pll: assert property ($rose(link_ser_on) |-> link_pll_on)
    else $error("link started with pll off");
  // alarm moves only with a sample or a register write
  a_alarm_quiet: assert property ((!adc_valid && spi_csb_b) [*4] |-> $stable(level_alarm_pin))
    else $error("alarm moved without cause");
endmodule // adcdo_checker

bind adcdo_top adcdo_checker i_chk (.sys_clk, .rst_b, .spi_csb_b, .spi_sdio_oe, .adc_valid,
  .level_alarm_pin, .link_pll_on, .link_ser_on, .lane_valid, .lane_ready, .lane_word);

// ===== dv/adcdo_rx_model.sv
`timescale 1ns/1ps
// ------
// link receiver model
// ------
module adcdo_rx_model (
  input  wire logic                   sys_clk,
  input  wire logic                   rst_b,
  input  wire logic                   lane_valid,
  input  wire adcdo_pkg::adcdo_lane_s lane_word,
  input  wire logic                   stall_en,
  input  wire logic                   sync_hold,
  output logic                        lane_ready,
  output logic                        sync_request_input_b,
  output logic [15:0]                 last_data,
  output int                          n_ctrl
);
  initial begin
    lane_ready = 1'b1;
    sync_request_input_b = 1'b0;
  end
  // slow reader fills the fifo; sync held low until told
  always @(negedge sys_clk) begin
    lane_ready <= stall_en ? ($urandom_range(3) == 0) : 1'b1;
    sync_request_input_b <= !sync_hold;
  end
  // take words at the handshake edge
  always @(posedge sys_clk) begin
    if (rst_b && lane_valid && lane_ready) begin
      if (lane_word.ctrl) n_ctrl <= n_ctrl + 1;
      else last_data <= lane_word.data;
    end
  end
endmodule // adcdo_rx_model

// ===== dv/test_adc_digital_output_control.sv
`timescale 1ns/1ps
// ------
// bench top
// ------
module test_adc_digital_output_control;
  logic                   sys_clk, rst_b, spi_sclk, spi_csb_b, sdio_tb, power_down_pin;
  logic                   adc_valid, adc_ovr, sysref_in, stall_en, sync_hold, exp_fd;
  logic                   spi_sdio_out, spi_sdio_oe, level_alarm_pin, adc_power_down;
  logic                   adc_standby, link_pll_on, link_ser_on, lane_valid, lane_ready;
  logic                   sync_request_input_b;
  logic [13:0]            adc_data, d;
  logic [15:0]            last_data;
  logic [7:0]             rd;
  logic [12:0]            pwr [8];
  logic [15:0]            fdr [7];
  logic [21:0]            fmt [3];
  int                     fail_count, n_checks, n_ctrl, mag, cnt;
  adcdo_pkg::adcdo_lane_s lane_word;
  // shared data wire: device wins while it drives
  wire                    sdio_w = spi_sdio_oe ? spi_sdio_out : sdio_tb;

  adcdo_top #(.MF_LEN(4), .ILAS_MF(1)) i_dut (.sys_clk, .rst_b, .spi_sclk, .spi_csb_b,
    .spi_sdio_in(sdio_w), .spi_sdio_out, .spi_sdio_oe, .power_down_pin, .adc_valid, .adc_data,
    .adc_ovr, .sysref_in, .sync_request_input_b, .level_alarm_pin, .adc_power_down,
    .adc_standby, .link_pll_on, .link_ser_on, .lane_valid, .lane_ready, .lane_word);
  adcdo_rx_model i_rx (.sys_clk, .rst_b, .lane_valid, .lane_word, .stall_en, .sync_hold,
    .lane_ready, .sync_request_input_b, .last_data, .n_ctrl);

  // clock
  initial begin
    sys_clk = 0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // one frame; read bits taken late in the low half, well after the shift
  task automatic spi(input logic rdn, input logic [7:0] a, input logic [7:0] v);
    logic [23:0] f;
    f = {rdn, 7'h00, a, v};
    spi_csb_b = 0;
    for (int i = 23; i >= 0; i--) begin
      sdio_tb = f[i];
      tick(4);
      if (i < 8) rd[i] = sdio_w;
      spi_sclk = 1;
      tick(4);
      spi_sclk = 0;
    end
    tick(4);
    spi_csb_b = 1;
    tick(2);
  endtask

  // sample strobes one every other cycle
  task automatic samp(input logic [13:0] v, input int n);
    adc_data = v;
    repeat (n) begin
      adc_valid = 1;
      tick(1);
      adc_valid = 0;
      tick(1);
    end
  endtask

  // watchdog, far beyond the expected run
  initial begin
    #300_000;
    fail_count++;
    final_report();
  end

  // main sequence
  initial begin
    {spi_sclk, sdio_tb, power_down_pin, adc_valid, adc_ovr, sysref_in, stall_en, rst_b} = '0;
    {spi_csb_b, sync_hold, exp_fd, adc_data} = {2'b11, 15'h0};
    pwr = '{{8'h00, 5'h03}, {8'h01, 5'h0B}, {8'h02, 5'h07}, {8'h04, 5'h00},
            {8'h08, 5'h02}, {8'h30, 5'h16}, {8'h20, 5'h17}, {8'h00, 5'h03}};
    fdr = '{16'h4764, 16'h4800, 16'h4932, 16'h4A00, 16'h4B03, 16'h4C00, 16'h4501};
    fmt = '{{14'h0000, 8'h01}, {14'h2000, 8'h00}, {14'h3FFF, 8'h05}};
    void'($urandom(1358));
    tick(12);
    rst_b = 1;
    tick(2);
    spi(1, 8'h5F, 0);
    check(rd, 8'h16);
    foreach (fdr[i]) begin
      spi(0, fdr[i][15:8], fdr[i][7:0]);
      spi(1, fdr[i][15:8], 0);
      check(rd, fdr[i][7:0]);
    end
    d = 14'($urandom);
    spi(0, 8'h64, d[7:0]);
    spi(1, 8'h64, 0);
    check(rd, d[7:0]);
    spi(1, 8'h33, 0);
    check(rd, 0);
    $display("register test done");
    // upper 100, lower 50, dwell 3
    for (int i = 0; i < 40; i++) begin
      mag = ($urandom_range(3) == 0) ? 100 + $urandom_range(50) : $urandom_range(60);
      if (mag > 100) begin
        exp_fd = 1;
        cnt = 0;
      end else if (mag < 50) begin
        cnt++;
        if (cnt >= 3) exp_fd = 0;
      end else begin
        cnt = 0;
      end
      samp(14'($urandom_range(1) ? -mag : mag), 1);
      tick(2);
      check(level_alarm_pin, exp_fd);
    end
    for (int b = 1; b >= 0; b--) begin
      spi(0, 8'h45, {5'h01, b[0], 2'h1});
      tick(3);
      check(level_alarm_pin, b[0]);
    end
    spi(0, 8'h45, 8'h10);
    for (int b = 1; b >= 0; b--) begin
      adc_ovr = b[0];
      samp(0, 1);
      tick(2);
      check(level_alarm_pin, b[0]);
    end
    $display("level detect test done");
    foreach (pwr[i]) begin
      power_down_pin = pwr[i][4];
      spi(0, 8'h08, pwr[i][12:5]);
      tick(4);
      check({adc_power_down, adc_standby, link_pll_on, link_ser_on}, pwr[i][3:0]);
    end
    spi(0, 8'h5F, 8'h17);
    tick(4);
    check(link_ser_on, 0);
    spi(0, 8'h5F, 8'h16);
    $display("power test done");
    samp(d, 10);
    check(16'(n_ctrl > 0), 1);
    // enabling the buffer while sync is held low realigns at once
    spi(0, 8'h3A, 8'h11);
    cnt = n_ctrl;
    samp(d, 12);
    tick(20);
    check(16'(n_ctrl - cnt), 16'd12);
    sync_hold = 0;
    foreach (fmt[i]) begin
      spi(0, 8'h14, fmt[i][7:0]);
      stall_en = 1;
      samp(d, 40);
      stall_en = 0;
      tick(20);
      check(last_data[15:2], d ^ fmt[i][21:8]);
    end
    $display("data path test done");
    final_report();
  end
endmodule // test_adc_digital_output_control

// ===== rtl/adcdo_defines.svh
`ifndef ADCDO_DEFINES_SVH
`define ADCDO_DEFINES_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define ADCDO_A_PWR   8'h08
`define ADCDO_A_OFMT  8'h14
`define ADCDO_A_USR0  8'h19
`define ADCDO_A_USR3  8'h1C
`define ADCDO_A_SYNC  8'h3A
`define ADCDO_A_DCC   8'h40
`define ADCDO_A_DCLO  8'h41
`define ADCDO_A_DCHI  8'h42
`define ADCDO_A_FDC   8'h45
`define ADCDO_A_UTL   8'h47
`define ADCDO_A_UTH   8'h48
`define ADCDO_A_LTL   8'h49
`define ADCDO_A_LTH   8'h4A
`define ADCDO_A_DWL   8'h4B
`define ADCDO_A_DWH   8'h4C
`define ADCDO_A_QCFG  8'h5E
`define ADCDO_A_LC1   8'h5F
`define ADCDO_A_LC2   8'h60
`define ADCDO_A_LC3   8'h61
`define ADCDO_A_DID   8'h64
`define ADCDO_A_BID   8'h65
`define ADCDO_A_LID   8'h67
// ----------------------------------------
// reset values and codes
// ----------------------------------------
`define ADCDO_LC1_RST 8'h16
`define ADCDO_PM_DOWN 2'h1
`define ADCDO_PM_STBY 2'h2
`define ADCDO_FMT_OB  2'h0
`define ADCDO_ILAS_ON 2'h1
`define ADCDO_ILAS_RP 2'h3
`define ADCDO_INJ_10B 2'h1
`define ADCDO_TP_CHK  4'h1
`define ADCDO_TP_TOG  4'h2
`define ADCDO_TP_PN23 4'h3
`define ADCDO_TP_PN9  4'h4
`define ADCDO_TP_UREP 4'h5
`define ADCDO_TP_UONE 4'h6
`define ADCDO_TP_PN7  4'hC
`define ADCDO_TP_PN15 4'hD
`define ADCDO_DC_KMAX 4'hD
`define ADCDO_DC_BASE 6'h0E
`define ADCDO_DC_FRAC 24
`define ADCDO_K_IDLE  16'hBCBC
`define ADCDO_K_ILSA  16'h1C1C
`define ADCDO_K_ILSE  16'h7C7C
`define ADCDO_CHK_A   16'hAAAA
`define ADCDO_SPI_HDR 5'h0F
`define ADCDO_SPI_END 5'h17
`define ADCDO_SPI_DAT 5'h10
`endif

// ===== rtl/adcdo_pkg.sv
package adcdo_pkg;
  // one word toward the serializer
  typedef struct packed {
    logic        ctrl;
    logic        raw10;
    logic [15:0] data;
  } adcdo_lane_s;

  typedef enum logic [1:0] {
    LNK_OFF,
    LNK_SYNC,
    LNK_ILAS,
    LNK_DATA
  } adcdo_link_e;
endpackage

// ===== rtl/adcdo_top.sv
`timescale 1ns/1ps
`include "adcdo_defines.svh"

// ----------------------------------------
// lane word fifo
// ----------------------------------------
module adcdo_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("depth");
  end
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0]      wp_ff;
  logic [AW:0]      rp_ff;
  logic             push;
  logic             pop;

  // full when pointers differ only in wrap bit
  assign in_ready  = (wp_ff ^ rp_ff) != {1'b1, {AW{1'b0}}};
  assign out_valid = wp_ff != rp_ff;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_ff[rp_ff[AW-1:0]];

  // storage has no reset, pointers guard it
  always_ff @(posedge sys_clk) begin
    if (push) mem_ff[wp_ff[AW-1:0]] <= in_data;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wp_ff <= '0;
      rp_ff <= '0;
    end else begin
      if (push) wp_ff <= wp_ff + 1'b1;
      if (pop)  rp_ff <= rp_ff + 1'b1;
    end
  end
endmodule // adcdo_fifo

// ----------------------------------------
// converter back end and link control
// ----------------------------------------
module adcdo_top #(
  parameter int SMP_W   = 14,
  parameter int FIFO_D  = 8,
  parameter int MF_LEN  = 32,
  parameter int ILAS_MF = 4
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst_b,
  input  wire logic                 spi_sclk,
  input  wire logic                 spi_csb_b,
  input  wire logic                 spi_sdio_in,
  output logic                      spi_sdio_out,
  output logic                      spi_sdio_oe,
  input  wire logic                 power_down_pin,
  input  wire logic                 adc_valid,
  input  wire logic [SMP_W-1:0]     adc_data,
  input  wire logic                 adc_ovr,
  input  wire logic                 sysref_in,
  input  wire logic                 sync_request_input_b,
  output logic                      level_alarm_pin,
  output logic                      adc_power_down,
  output logic                      adc_standby,
  output logic                      link_pll_on,
  output logic                      link_ser_on,
  output logic                      lane_valid,
  input  wire logic                 lane_ready,
  output adcdo_pkg::adcdo_lane_s    lane_word
);
  initial begin
    if (SMP_W != 14) $error("sample width");
    if (MF_LEN < 4 || MF_LEN > 256) $error("multiframe");
    if (ILAS_MF < 1 || ILAS_MF > 15) $error("ilas");
  end

  // ----------------------------------------
  // serial control port and register file
  // ----------------------------------------
  logic [7:0]  regs_ff [256];
  logic        sclk_d_ff;
  logic [4:0]  bit_ff;
  logic [15:0] shin_ff;
  logic [7:0]  shout_ff;
  logic [7:0]  addr_ff;
  logic        rd_ff;
  logic        oe_ff;
  logic        sck_rise;
  logic        sck_fall;
  logic        wr_en;
  logic [7:0]  wr_data;
  logic [15:0] dc_val_ff;
  logic        arm_ff;

  assign sck_rise = spi_sclk & ~sclk_d_ff;
  assign sck_fall = ~spi_sclk & sclk_d_ff;
  assign wr_en    = sck_rise & ~spi_csb_b & ~rd_ff & (bit_ff == `ADCDO_SPI_END);
  assign wr_data  = {shin_ff[6:0], spi_sdio_in};
  assign spi_sdio_out = shout_ff[7];
  assign spi_sdio_oe  = oe_ff;

  // writable locations only, others ignore writes
  function automatic logic is_rw(input logic [7:0] a);
    if (a == `ADCDO_A_DCLO || a == `ADCDO_A_DCHI) return 1'b0;
    else if (a == `ADCDO_A_PWR || a == `ADCDO_A_OFMT) return 1'b1;
    else if (a >= `ADCDO_A_USR0 && a <= `ADCDO_A_USR3) return 1'b1;
    else if (a == `ADCDO_A_SYNC || a == `ADCDO_A_DCC) return 1'b1;
    else if (a >= `ADCDO_A_FDC && a <= `ADCDO_A_DWH) return 1'b1;
    else if (a >= `ADCDO_A_QCFG && a <= `ADCDO_A_LC3) return 1'b1;
    else if (a == `ADCDO_A_DID || a == `ADCDO_A_BID) return 1'b1;
    else if (a == `ADCDO_A_LID) return 1'b1;
    else return 1'b0;
  endfunction

  // read mux, unmapped reads give zero
  function automatic logic [7:0] rd_byte(input logic [7:0] a);
    if (a == `ADCDO_A_DCLO) return dc_val_ff[7:0];
    else if (a == `ADCDO_A_DCHI) return dc_val_ff[15:8];
    else if (is_rw(a)) return regs_ff[a];
    else return 8'h00;
  endfunction

  // sclk is sampled, so it must run well below sys_clk
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_d_ff <= 1'b0;
      bit_ff    <= '0;
      shin_ff   <= '0;
      shout_ff  <= '0;
      addr_ff   <= '0;
      rd_ff     <= 1'b0;
      oe_ff     <= 1'b0;
    end else begin
      sclk_d_ff <= spi_sclk;
      if (spi_csb_b) begin
        bit_ff <= '0;
        rd_ff  <= 1'b0;
        oe_ff  <= 1'b0;
      end else if (sck_rise) begin
        shin_ff <= {shin_ff[14:0], spi_sdio_in};
        if (bit_ff != `ADCDO_SPI_END + 5'h01) bit_ff <= bit_ff + 5'h01;
        if (bit_ff == `ADCDO_SPI_HDR) begin
          rd_ff   <= shin_ff[14];
          addr_ff <= {shin_ff[6:0], spi_sdio_in};
        end
      end else if (sck_fall && rd_ff && bit_ff >= `ADCDO_SPI_DAT) begin
        oe_ff <= bit_ff <= `ADCDO_SPI_END;
        if (bit_ff == `ADCDO_SPI_DAT) shout_ff <= rd_byte(addr_ff);
        else shout_ff <= {shout_ff[6:0], 1'b0};
      end
    end
  end

  // register writes
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 256; i++) regs_ff[i] <= 8'h00;
      regs_ff[`ADCDO_A_LC1] <= `ADCDO_LC1_RST;
    end else if (wr_en && is_rw(addr_ff)) begin
      regs_ff[addr_ff] <= wr_data;
    end
  end

  // ----------------------------------------
  // field views
  // ----------------------------------------
  logic [7:0]  pwr;
  logic [7:0]  ofmt;
  logic [7:0]  syc;
  logic [7:0]  dcc;
  logic [7:0]  fdc;
  logic [7:0]  lc1;
  logic [7:0]  lc2;
  logic [7:0]  lc3;
  logic [14:0] up_thr;
  logic [14:0] lo_thr;
  logic [15:0] dwell;

  assign pwr    = regs_ff[`ADCDO_A_PWR];
  assign ofmt   = regs_ff[`ADCDO_A_OFMT];
  assign syc    = regs_ff[`ADCDO_A_SYNC];
  assign dcc    = regs_ff[`ADCDO_A_DCC];
  assign fdc    = regs_ff[`ADCDO_A_FDC];
  assign lc1    = regs_ff[`ADCDO_A_LC1];
  assign lc2    = regs_ff[`ADCDO_A_LC2];
  assign lc3    = regs_ff[`ADCDO_A_LC3];
  assign up_thr = {regs_ff[`ADCDO_A_UTH][6:0], regs_ff[`ADCDO_A_UTL]};
  assign lo_thr = {regs_ff[`ADCDO_A_LTH][6:0], regs_ff[`ADCDO_A_LTL]};
  assign dwell  = {regs_ff[`ADCDO_A_DWH], regs_ff[`ADCDO_A_DWL]};

  // ----------------------------------------
  // power control
  // ----------------------------------------
  logic link_hold;

  // pin forces full power-down or standby, pwr[5] selects which
  assign adc_power_down = pwr[1:0] == `ADCDO_PM_DOWN
                        | (power_down_pin & ~pwr[5]);
  assign adc_standby    = pwr[1:0] == `ADCDO_PM_STBY
                        | (power_down_pin & pwr[5]);
  assign link_hold = lc1[0]
                   | pwr[3:2] == `ADCDO_PM_DOWN | pwr[3:2] == `ADCDO_PM_STBY
                   | (pwr[4] & pwr[5] & power_down_pin);
  assign link_pll_on = pwr[3:2] != `ADCDO_PM_DOWN;

  // ----------------------------------------
  // offset correction
  // ----------------------------------------
  logic               smp_tick;
  logic signed [47:0] acc_ff;
  logic signed [47:0] x_fix;
  logic [3:0]         k_eff;
  logic [5:0]         shamt;
  logic signed [15:0] corr;
  logic signed [16:0] sum;
  logic [13:0]        smp_c;

  assign smp_tick = adc_valid & ~adc_power_down & ~adc_standby;
  assign k_eff = dcc[5:2] > `ADCDO_DC_KMAX ? `ADCDO_DC_KMAX : dcc[5:2];
  assign shamt = `ADCDO_DC_BASE + {2'b00, k_eff};
  assign x_fix = 48'(signed'(adc_data)) <<< `ADCDO_DC_FRAC;
  assign corr  = -16'(acc_ff >>> `ADCDO_DC_FRAC);
  assign sum   = 17'(signed'(adc_data)) + (dcc[1] ? 17'(signed'(dc_val_ff)) : 17'sh0);

  // clip to the sample range after summing
  always_comb begin
    if (sum > 17'sh1FFF) smp_c = 14'h1FFF;
    else if (sum < -17'sh2000) smp_c = 14'h2000;
    else smp_c = sum[13:0];
  end

  // first-order average, one step per sample
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_ff    <= '0;
      dc_val_ff <= '0;
    end else if (smp_tick && !dcc[6]) begin
      acc_ff    <= acc_ff + ((x_fix - acc_ff) >>> shamt);
      dc_val_ff <= corr;
    end
  end

  // ----------------------------------------
  // level alarm
  // ----------------------------------------
  logic [14:0] mag;
  logic [15:0] dw_cnt_ff;
  logic        fd_ff;
  logic        ovr_ff;
  logic        below;

  assign mag   = smp_c[13] ? 15'(-signed'(smp_c)) : {1'b0, smp_c};
  assign below = mag < lo_thr;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      fd_ff     <= 1'b0;
      dw_cnt_ff <= '0;
      ovr_ff    <= 1'b0;
    end else if (smp_tick) begin
      ovr_ff <= adc_ovr;
      if (!below) dw_cnt_ff <= '0;
      else if (dw_cnt_ff != 16'hFFFF) dw_cnt_ff <= dw_cnt_ff + 16'h0001;
      if (fdc[0] && mag > up_thr) fd_ff <= 1'b1;
      else if (below && dw_cnt_ff + 17'h00001 >= {1'b0, dwell}) fd_ff <= 1'b0;
    end
  end

  // pin is registered so it never glitches
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) level_alarm_pin <= 1'b0;
    else if (fdc[3]) level_alarm_pin <= fdc[2];
    else level_alarm_pin <= fdc[4] ? ovr_ff : (fd_ff & fdc[0]);
  end

  // ----------------------------------------
  // sysref, sync and frame divider
  // ----------------------------------------
  logic       sysref_d_ff;
  logic       sync_d_ff;
  logic       sref_rise;
  logic       sync_act;
  logic       sync_ass;
  logic       div_rst;
  logic [7:0] mf_cnt_ff;
  logic       mf_end;

  assign sref_rise = syc[1] & sysref_in & ~sysref_d_ff;
  assign sync_act  = syc[0] & ~sync_request_input_b;
  assign sync_ass  = sync_act & ~sync_d_ff;
  assign div_rst   = sref_rise & (~syc[2] | arm_ff);
  assign mf_end    = mf_cnt_ff == 8'(MF_LEN - 1);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sysref_d_ff <= 1'b0;
      sync_d_ff   <= 1'b0;
      arm_ff      <= 1'b0;
    end else begin
      sysref_d_ff <= sysref_in;
      sync_d_ff   <= sync_act;
      // write arms, next edge consumes; a new write wins
      if (wr_en && addr_ff == `ADCDO_A_SYNC) arm_ff <= wr_data[2];
      else if (div_rst) arm_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) mf_cnt_ff <= '0;
    else if (div_rst) mf_cnt_ff <= '0;
    else if (smp_tick) mf_cnt_ff <= mf_end ? 8'h00 : mf_cnt_ff + 8'h01;
  end

  // ----------------------------------------
  // link state machine and payload
  // ----------------------------------------
  adcdo_pkg::adcdo_link_e st_ff;
  adcdo_pkg::adcdo_lane_s wd;
  logic        f_ready;
  logic        f_push;
  logic        realign;
  logic [3:0]  ilas_ff;
  logic [8:0]  lfsr_ff;
  logic [22:0] pn_ff;
  logic        tog_ff;
  logic [1:0]  uidx_ff;
  logic        udone_ff;
  logic [13:0] smp_o;
  logic [1:0]  tail;
  logic [15:0] pat;
  logic [7:0]  ub;

  assign f_push  = smp_tick & st_ff != adcdo_pkg::LNK_OFF;
  assign realign = (syc[4] & sync_ass) | (syc[3] & sref_rise);
  assign link_ser_on = st_ff != adcdo_pkg::LNK_OFF;

  // one lfsr step, taps by pattern code
  function automatic logic [22:0] pn_next(input logic [22:0] s, input logic [3:0] m);
    logic fb;
    fb = 1'b0;
    case (m)
      `ADCDO_TP_PN7:  fb = s[6] ^ s[5];
      `ADCDO_TP_PN9:  fb = s[8] ^ s[4];
      `ADCDO_TP_PN15: fb = s[14] ^ s[13];
      default:        fb = s[22] ^ s[17];
    endcase
    return {s[21:0], fb};
  endfunction

  // state moves forward from SYNC and ILAS only when the fifo takes a word
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff   <= adcdo_pkg::LNK_OFF;
      ilas_ff <= '0;
    end else if (link_hold) begin
      st_ff <= adcdo_pkg::LNK_OFF;
    end else if (st_ff == adcdo_pkg::LNK_OFF) begin
      st_ff <= adcdo_pkg::LNK_SYNC;
    end else if (realign) begin
      // realign events are single pulses, never wait for a sample
      st_ff <= adcdo_pkg::LNK_SYNC;
    end else if (f_push && f_ready) begin
      case (st_ff)
        adcdo_pkg::LNK_SYNC: begin
          ilas_ff <= '0;
          if (!sync_act && mf_end)
            st_ff <= lc1[3:2] == 2'b00 ? adcdo_pkg::LNK_DATA : adcdo_pkg::LNK_ILAS;
        end
        adcdo_pkg::LNK_ILAS: begin
          if (mf_end) ilas_ff <= ilas_ff + 4'h1;
          // repeat mode never leaves alignment
          if (mf_end && ilas_ff == 4'(ILAS_MF - 1) && lc1[3:2] != `ADCDO_ILAS_RP)
            st_ff <= adcdo_pkg::LNK_DATA;
        end
        default: ;
      endcase
    end
  end

  // pattern generators step once per accepted word
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lfsr_ff  <= 9'h1FF;
      pn_ff    <= '1;
      tog_ff   <= 1'b0;
      uidx_ff  <= '0;
      udone_ff <= 1'b0;
    end else if (lc3[3:0] == 4'h0 || st_ff == adcdo_pkg::LNK_OFF) begin
      pn_ff    <= '1;
      uidx_ff  <= '0;
      udone_ff <= 1'b0;
      if (f_push && f_ready) lfsr_ff <= {lfsr_ff[7:0], lfsr_ff[8] ^ lfsr_ff[4]};
    end else if (f_push && f_ready) begin
      lfsr_ff <= {lfsr_ff[7:0], lfsr_ff[8] ^ lfsr_ff[4]};
      pn_ff   <= pn_next(pn_ff, lc3[3:0]);
      tog_ff  <= ~tog_ff;
      uidx_ff <= uidx_ff + 2'h1;
      if (uidx_ff == 2'h3) udone_ff <= 1'b1;
    end
  end

  assign ub = regs_ff[`ADCDO_A_USR0 + {6'h00, uidx_ff}];

  // test pattern select
  always_comb begin
    case (lc3[3:0])
      `ADCDO_TP_CHK:  pat = tog_ff ? ~`ADCDO_CHK_A : `ADCDO_CHK_A;
      `ADCDO_TP_TOG:  pat = tog_ff ? 16'hFFFF : 16'h0000;
      `ADCDO_TP_PN23,
      `ADCDO_TP_PN9,
      `ADCDO_TP_PN7,
      `ADCDO_TP_PN15: pat = pn_ff[15:0];
      `ADCDO_TP_UREP: pat = {ub, ub};
      `ADCDO_TP_UONE: pat = udone_ff ? 16'h0000 : {ub, ub};
      default:        pat = 16'h0000;
    endcase
  end

  // sample formatting, disable overrides invert
  always_comb begin
    smp_o = ofmt[2] ? ~smp_c : smp_c;
    if (ofmt[1:0] == `ADCDO_FMT_OB) smp_o[13] = ~smp_o[13];
    if (ofmt[4]) smp_o = '0;
    if (ofmt[7:5] != 3'b000) tail = {ovr_ff, 1'b0};
    else if (lc1[6]) tail = lfsr_ff[1:0];
    else tail = 2'b00;
  end

  // word assembly per state
  always_comb begin
    wd.ctrl  = 1'b0;
    wd.raw10 = 1'b0;
    wd.data  = {smp_o, tail};
    case (st_ff)
      adcdo_pkg::LNK_SYNC: begin
        wd.ctrl = 1'b1;
        wd.data = `ADCDO_K_IDLE;
      end
      adcdo_pkg::LNK_ILAS: begin
        wd.ctrl = mf_cnt_ff == 8'h00 || mf_end;
        wd.data = mf_cnt_ff == 8'h00 ? `ADCDO_K_ILSA
                : mf_end ? `ADCDO_K_ILSE
                : {regs_ff[`ADCDO_A_DID], regs_ff[`ADCDO_A_BID][3:0],
                   regs_ff[`ADCDO_A_LID][3:0]};
      end
      adcdo_pkg::LNK_DATA: begin
        if (lc1[5]) wd.data = {8'h00, mf_cnt_ff};
        if (lc3[3:0] != 4'h0) begin
          wd.data  = pat;
          wd.raw10 = lc3[5:4] == `ADCDO_INJ_10B;
        end
      end
      default: ;
    endcase
    if (lc2[1]) wd.data = ~wd.data;
  end

  adcdo_fifo #(
    .WIDTH ($bits(adcdo_pkg::adcdo_lane_s)),
    .DEPTH (FIFO_D)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_b     (rst_b),
    .in_valid  (f_push),
    .in_ready  (f_ready),
    .in_data   (wd),
    .out_valid (lane_valid),
    .out_ready (lane_ready),
    .out_data  (lane_word)
  );
endmodule // adcdo_top
